//--- core/rx_pkg.sv
// shared constants and types for the serial receiver
package rx_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INT_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_RX_STATUS = 8'h18;
    localparam logic [7:0] ADDR_TX_DATA = 8'h19;
    localparam logic [7:0] ADDR_RX_DATA = 8'h1A;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h1D;
    localparam logic [7:0] ADDR_INT_ENABLES = 8'h8C;
    localparam logic [7:0] ADDR_TX_STATUS = 8'h98;
    localparam logic [7:0] ADDR_BAUD_DIV = 8'h99;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_PORT_EN = 7;
    localparam int BIT_NINE = 6;
    localparam int BIT_SINGLE = 5;
    localparam int BIT_CONT = 4;
    localparam int BIT_ADDR_DET = 3;
    localparam int BIT_FRAME = 2;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_NINTH = 0;
    localparam int BIT_RX_FLAG = 5;
    localparam int BIT_CLK_SRC = 7;
    localparam int BIT_SYNC_MODE = 4;
    localparam int BIT_HIGH_SPEED = 2;
    localparam int EV_WORD = 0;
    localparam int EV_FRAME = 1;
    localparam int EV_OVERRUN = 2;
    localparam int EV_W = 3;
    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] RX_CTRL_MASK = 8'hF8;
    localparam logic [7:0] TX_STATUS_RESET = 8'h02;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [EV_W-1:0] EV_NONE = 3'h0;
    // ------------------------------------------------------------
    // timing counts (ticks of the oversample clock)
    // ------------------------------------------------------------
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [1:0] LOW_SPEED_FILL = 2'h3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b11,
        ST_STOP = 2'b10
    } rx_state_e;
endpackage

//--- core/baud_if.sv
// link between the receiver and its oversample tick generator
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
    logic [7:0] divisor;
    logic high_speed;
    logic run;
    logic tick;
    modport gen (input divisor, input high_speed, input run, output tick);
    modport user (output divisor, output high_speed, output run,
                  input tick);
endinterface
`default_nettype wire

//--- core/pin_sync.sv
// two-stage synchronisers for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // raw and synchronised levels
    input wire logic [W-1:0] pin_raw,
    output logic [W-1:0] pin_sync_q
);
    // ------------------------------------------------------------
    // one pair of flops per pin; idle level is high
    // ------------------------------------------------------------
    logic [W-1:0] meta_q;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    meta_q[i] <= 1'b1;
                    pin_sync_q[i] <= 1'b1;
                end else begin
                    meta_q[i] <= pin_raw[i];
                    pin_sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- core/baud_gen.sv
// oversample tick generator driven by the baud divisor
`timescale 1ns/1ps
`default_nettype none
module baud_gen
    import rx_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // control and tick
    baud_if.gen bus
);
    // ------------------------------------------------------------
    // period: divisor+1 clocks, or four times that at low speed
    // ------------------------------------------------------------
    logic [9:0] cnt_q;
    wire logic [9:0] limit = bus.high_speed ? {2'h0, bus.divisor}
                                            : {bus.divisor, LOW_SPEED_FILL};
    wire logic at_end = (cnt_q == limit);
    assign bus.tick = bus.run & at_end;
    // counter restarts while idle so the first tick is a full period
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 10'h000;
        end else if (!bus.run || at_end) begin
            cnt_q <= 10'h000;
        end else begin
            cnt_q <= cnt_q + 10'h001;
        end
    end
endmodule
`default_nettype wire

//--- core/serial_port_receiver.sv
// receive side of the serial port: async and sync master/slave
`timescale 1ns/1ps
`default_nettype none
module serial_port_receiver
    import rx_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // serial pins
    input wire logic data_pin_i,
    input wire logic clock_pin_i,
    output logic clock_pin_o,
    output logic clock_pin_oe_n,
    output logic pins_to_port,
    // core side
    input wire logic sleep,
    input wire logic global_interrupt_enable,
    output logic receive_interrupt,
    output logic wake,
    output logic vector_request,
    output logic irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] rx_ctrl_q;
    logic [7:0] tx_status_q;
    logic [7:0] tx_data_q;
    logic [7:0] baud_div_q;
    logic [7:0] int_en_q;
    logic [7:0] data_q;
    logic [EV_W-1:0] evt_q;
    logic [EV_W-1:0] evt_mask_q;
    logic full_q;
    logic ninth_q;
    logic frame_q;
    logic overrun_q;
    logic [7:0] reg_rdata_q;
    rx_state_e st_q;
    rx_state_e st_d;
    logic [3:0] sub_q;
    logic [3:0] sub_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [8:0] shift_q;
    logic ck_q;
    logic ck_d;
    logic ck_prev_q;
    logic shift_en;
    logic done;
    logic frame_bad;

    // ------------------------------------------------------------
    // pin synchronisers and tick generator
    // ------------------------------------------------------------
    logic [1:0] pins_s;
    pin_sync #(.W(2)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_raw({clock_pin_i, data_pin_i}),
        .pin_sync_q(pins_s)
    );
    wire logic rx_s = pins_s[0];
    wire logic ck_s = pins_s[1];

    baud_if bif ();
    baud_gen u_baud (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .bus(bif.gen)
    );

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    wire logic port_en = rx_ctrl_q[BIT_PORT_EN];
    wire logic nine = rx_ctrl_q[BIT_NINE];
    wire logic single = rx_ctrl_q[BIT_SINGLE];
    wire logic cont = rx_ctrl_q[BIT_CONT];
    wire logic addr_det = rx_ctrl_q[BIT_ADDR_DET];
    wire logic sync_mode = tx_status_q[BIT_SYNC_MODE];
    wire logic master = sync_mode & tx_status_q[BIT_CLK_SRC];
    // master listens on single or continuous; slave only on continuous
    wire logic want_rx = master ? (cont | single) : cont;
    // only the slave keeps going with the core asleep
    wire logic awake_ok = !sleep | (sync_mode & !master);
    // an overrun halts reception until continuous receive is cleared
    wire logic rx_on = port_en & want_rx & awake_ok & !overrun_q;
    wire logic bit_last = bit_q == (nine ? LAST_BIT_9 : LAST_BIT_8);
    wire logic wr_status = reg_wr & hit(reg_addr, ADDR_RX_STATUS);
    wire logic rd_data = reg_rd & hit(reg_addr, ADDR_RX_DATA);

    assign bif.divisor = baud_div_q;
    assign bif.high_speed = tx_status_q[BIT_HIGH_SPEED];
    assign bif.run = rx_on & (!sync_mode | master);

    // ------------------------------------------------------------
    // sync sampling edge: own falling clock or the master's
    // ------------------------------------------------------------
    wire logic half_end = bif.tick & (sub_q == TICK_MID);
    wire logic sync_fall = master ? (half_end & ck_q)
                                  : (ck_prev_q & !ck_s);

    // ------------------------------------------------------------
    // receive sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        sub_d = sub_q;
        bit_d = bit_q;
        ck_d = ck_q;
        shift_en = 1'b0;
        done = 1'b0;
        frame_bad = 1'b0;
        if (!rx_on) begin
            st_d = ST_IDLE;
            sub_d = 4'h0;
            bit_d = 4'h0;
            ck_d = 1'b0;
        end else if (sync_mode) begin
            st_d = ST_DATA;
            if (st_q != ST_DATA) begin
                sub_d = 4'h0;
                bit_d = 4'h0;
            end else begin
                if (master && bif.tick) begin
                    sub_d = half_end ? 4'h0 : sub_q + 4'h1;
                    ck_d = half_end ? !ck_q : ck_q;
                end
                if (sync_fall) begin
                    shift_en = 1'b1;
                    done = bit_last;
                    bit_d = bit_last ? 4'h0 : bit_q + 4'h1;
                end
            end
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (!rx_s) begin
                        st_d = ST_START;
                        sub_d = 4'h0;
                        bit_d = 4'h0;
                    end
                end
                ST_START: begin
                    // a start bit gone high by mid-bit was a glitch
                    if (bif.tick && sub_q == TICK_MID) begin
                        sub_d = 4'h0;
                        st_d = rx_s ? ST_IDLE : ST_DATA;
                    end else if (bif.tick) begin
                        sub_d = sub_q + 4'h1;
                    end
                end
                ST_DATA: begin
                    if (bif.tick && sub_q == TICK_LAST) begin
                        sub_d = 4'h0;
                        shift_en = 1'b1;
                        st_d = bit_last ? ST_STOP : ST_DATA;
                        bit_d = bit_last ? bit_q : bit_q + 4'h1;
                    end else if (bif.tick) begin
                        sub_d = sub_q + 4'h1;
                    end
                end
                ST_STOP: begin
                    if (bif.tick && sub_q == TICK_LAST) begin
                        done = 1'b1;
                        frame_bad = !rx_s;
                        st_d = ST_IDLE;
                    end else if (bif.tick) begin
                        sub_d = sub_q + 4'h1;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // word assembly, lsb first
    // ------------------------------------------------------------
    wire logic [8:0] shift_d = shift_en ? {rx_s, shift_q[8:1]} : shift_q;
    wire logic [7:0] word_data = nine ? shift_d[7:0] : shift_d[8:1];
    wire logic word_ninth = nine & shift_d[8];
    // address words only: ninth bit clear means the word is dropped
    wire logic reject = !sync_mode & nine & addr_det & !word_ninth;
    wire logic accept = done & !reject;
    // one-word buffer; a read in the same cycle makes room
    wire logic load = accept & (!full_q | rd_data);
    wire logic overrun_set = accept & full_q & !rd_data;
    wire logic clear_single = done & master & !cont;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            sub_q <= 4'h0;
            bit_q <= 4'h0;
            ck_q <= 1'b0;
            ck_prev_q <= 1'b0;
            shift_q <= 9'h000;
        end else begin
            st_q <= st_d;
            sub_q <= sub_d;
            bit_q <= bit_d;
            ck_q <= ck_d;
            ck_prev_q <= ck_s;
            shift_q <= shift_d;
        end
    end

    // ------------------------------------------------------------
    // received data, ninth bit, framing and overrun
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_q <= ZERO_BYTE;
            ninth_q <= 1'b0;
            frame_q <= 1'b0;
            full_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            if (load) begin
                data_q <= word_data;
                ninth_q <= word_ninth;
                frame_q <= frame_bad;
            end
            // new word wins over a read in the same cycle
            full_q <= load | (full_q & !rd_data);
            overrun_q <= overrun_set | (overrun_q & cont);
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_ctrl_q <= ZERO_BYTE;
            tx_status_q <= TX_STATUS_RESET;
            tx_data_q <= ZERO_BYTE;
            baud_div_q <= ZERO_BYTE;
            int_en_q <= ZERO_BYTE;
            evt_mask_q <= EV_NONE;
        end else begin
            if (wr_status) begin
                rx_ctrl_q <= reg_wdata & RX_CTRL_MASK;
            end else if (clear_single) begin
                rx_ctrl_q[BIT_SINGLE] <= 1'b0;
            end
            if (reg_wr && hit(reg_addr, ADDR_TX_STATUS)) begin
                tx_status_q <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, ADDR_TX_DATA)) begin
                tx_data_q <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, ADDR_BAUD_DIV)) begin
                baud_div_q <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, ADDR_INT_ENABLES)) begin
                int_en_q <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, ADDR_EVT_MASK)) begin
                evt_mask_q <= reg_wdata[EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // sticky events, write one to clear; a new event wins
    // ------------------------------------------------------------
    wire logic [EV_W-1:0] evt_new = {overrun_set, load & frame_bad, load};
    wire logic [EV_W-1:0] evt_clr =
        (reg_wr && hit(reg_addr, ADDR_EVT_STATUS)) ? reg_wdata[EV_W-1:0]
                                                   : EV_NONE;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            evt_q <= EV_NONE;
        end else begin
            evt_q <= evt_new | (evt_q & ~evt_clr);
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        if (hit(reg_addr, ADDR_RX_STATUS)) begin
            rd_mux = rx_ctrl_q | 8'({frame_q, overrun_q, ninth_q});
        end else if (hit(reg_addr, ADDR_RX_DATA)) begin
            rd_mux = data_q;
        end else if (hit(reg_addr, ADDR_INT_FLAGS)) begin
            rd_mux = 8'(full_q) << BIT_RX_FLAG;
        end else if (hit(reg_addr, ADDR_INT_ENABLES)) begin
            rd_mux = int_en_q;
        end else if (hit(reg_addr, ADDR_TX_STATUS)) begin
            rd_mux = tx_status_q;
        end else if (hit(reg_addr, ADDR_BAUD_DIV)) begin
            rd_mux = baud_div_q;
        end else if (hit(reg_addr, ADDR_EVT_STATUS)) begin
            rd_mux = 8'(evt_q);
        end else if (hit(reg_addr, ADDR_EVT_MASK)) begin
            rd_mux = 8'(evt_mask_q);
        end else begin
            rd_mux = ZERO_BYTE; // write-only and unmapped read zero
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= ZERO_BYTE;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_mux;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // ------------------------------------------------------------
    // pins and interrupt outputs
    // ------------------------------------------------------------
    assign pins_to_port = port_en;
    assign clock_pin_o = ck_q;
    // clock is driven only by a running master; slave stays input
    assign clock_pin_oe_n = !(rx_on & master);
    assign receive_interrupt = full_q & int_en_q[BIT_RX_FLAG];
    assign wake = receive_interrupt;
    assign vector_request = receive_interrupt & global_interrupt_enable;
    assign irq = |(evt_q & evt_mask_q);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_flag_on_load: assert property (load |=> full_q && data_q ==
        $past(word_data)) else $error("word not loaded");
    a_flag_read_clear: assert property (rd_data && !load |=>
        !full_q) else $error("flag kept after read");
    a_overrun_set: assert property (overrun_set |=> overrun_q
        && $stable(data_q)) else $error("overrun lost");
    a_overrun_clear: assert property (overrun_q && !cont |=>
        !overrun_q) else $error("overrun not cleared");
    a_single_clear: assert property (clear_single && !wr_status
        |=> !single) else $error("single receive stuck");
    a_addr_reject: assert property (done && reject |=>
        $stable(data_q)) else $error("address filter failed");
    a_ninth_width: assert property (load && !nine |=>
        !ninth_q) else $error("ninth bit in eight-bit mode");
    a_port_off: assert property (!port_en |-> clock_pin_oe_n
        ##1 st_q == ST_IDLE) else $error("receiver ran disabled");
    a_sleep_halt: assert property (sleep && !sync_mode |=>
        st_q == ST_IDLE) else $error("async receive in sleep");
endmodule
`default_nettype wire

//--- sim/serial_sender.sv
// behavioural far-side sender: async transmitter and sync clock master
`timescale 1ns/1ps
`default_nettype none
module serial_sender #(
    parameter int BIT_NS = 320
) (
    // serial lines
    output logic data_line,
    output logic clock_line
);
    // idle: data high, clock stands low outside frames
    initial begin
        data_line = 1'b1;
        clock_line = 1'b0;
    end
    // async frame, lsb first; stop level chosen by caller
    task automatic send_async(input int n, input logic [8:0] v,
                              input logic stop);
        #7 data_line = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < n; i++) begin
            data_line = v[i];
            #(BIT_NS);
        end
        data_line = stop;
        #(BIT_NS);
        data_line = 1'b1;
    endtask
    // sync frame, 160 ns clock; data centred on the falling edge
    task automatic send_sync(input logic [7:0] v);
        #7;
        for (int i = 0; i < 8; i++) begin
            data_line = v[i];
            clock_line = 1'b1;
            #80 clock_line = 1'b0;
            #80;
        end
        data_line = ~v[7]; // released line must not echo the last bit
    endtask
endmodule
`default_nettype wire

//--- sim/serial_port_receiver_tb.sv
// self-checking bench for the serial port receiver
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module serial_port_receiver_tb
    import rx_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep = 1'b0;
    logic global_interrupt_enable = 1'b0;
    logic [7:0] reg_rdata;
    logic clock_pin_o, clock_pin_oe_n, pins_to_port;
    logic receive_interrupt, wake, vector_request, irq;
    wire data_line, clock_line;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    serial_port_receiver dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_pin_i(data_line),
        .clock_pin_i(clock_line), .clock_pin_o(clock_pin_o),
        .clock_pin_oe_n(clock_pin_oe_n), .pins_to_port(pins_to_port),
        .sleep(sleep),
        .global_interrupt_enable(global_interrupt_enable),
        .receive_interrupt(receive_interrupt), .wake(wake),
        .vector_request(vector_request), .irq(irq));
    serial_sender peer (.data_line(data_line), .clock_line(clock_line));
    // 50 MHz clock and a hang guard
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    // register port cycles; #1 lets the answering edge land first
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    // bounded wait for a loaded word, about two and a half frames long
    task automatic wait_ri();
        for (int i = 0; i < 400 && receive_interrupt !== 1'b1; i++)
            @(posedge clk_sys);
        #1;
        `CHK(receive_interrupt, 1'b1)
    endtask
    task automatic t_reset();
        chk_rd(ADDR_RX_STATUS, ZERO_BYTE);
        chk_rd(ADDR_TX_STATUS, TX_STATUS_RESET);
        chk_rd(ADDR_TX_DATA, ZERO_BYTE);
        chk_rd(8'h55, ZERO_BYTE);
        `CHK(pins_to_port, 1'b0)
        `CHK(clock_pin_oe_n, 1'b1)
        $display("done: reset values");
    endtask
    task automatic t_async8();
        wr(ADDR_BAUD_DIV, 8'h00);
        wr(ADDR_TX_STATUS, 8'h04);
        wr(ADDR_INT_ENABLES, 8'h20);
        wr(ADDR_RX_STATUS, 8'h90);
        `CHK(pins_to_port, 1'b1)
        peer.send_async(8, 9'h0A5, 1'b1);
        wait_ri();
        chk_rd(ADDR_INT_FLAGS, 8'h20);
        chk_rd(ADDR_RX_STATUS, 8'h90);
        chk_rd(ADDR_RX_DATA, 8'hA5);
        chk_rd(ADDR_INT_FLAGS, ZERO_BYTE);
        `CHK(receive_interrupt, 1'b0)
        $display("done: async eight bit");
    endtask
    task automatic t_addr();
        wr(ADDR_RX_STATUS, 8'hD8);
        peer.send_async(9, 9'h033, 1'b1);
        repeat (20) @(posedge clk_sys);
        `CHK(receive_interrupt, 1'b0)
        peer.send_async(9, 9'h1C3, 1'b1);
        wait_ri();
        chk_rd(ADDR_RX_STATUS, 8'hD9);
        chk_rd(ADDR_RX_DATA, 8'hC3);
        $display("done: address detect");
    endtask
    task automatic t_frame();
        wr(ADDR_RX_STATUS, 8'h90);
        peer.send_async(8, 9'h03C, 1'b0);
        wait_ri();
        chk_rd(ADDR_RX_STATUS, 8'h94);
        chk_rd(ADDR_RX_DATA, 8'h3C);
        peer.send_async(8, 9'h011, 1'b1);
        wait_ri();
        chk_rd(ADDR_RX_STATUS, 8'h90);
        chk_rd(ADDR_RX_DATA, 8'h11);
        // async reception must stand still while the core sleeps
        @(posedge clk_sys);
        sleep <= 1'b1;
        peer.send_async(8, 9'h022, 1'b1);
        repeat (20) @(posedge clk_sys);
        `CHK(receive_interrupt, 1'b0)
        sleep <= 1'b0;
        $display("done: framing error");
    endtask
    task automatic t_overrun();
        wr(ADDR_EVT_STATUS, 8'h07);
        wr(ADDR_EVT_MASK, 8'h00);
        peer.send_async(8, 9'h001, 1'b1);
        peer.send_async(8, 9'h002, 1'b1);
        repeat (20) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        chk_rd(ADDR_RX_STATUS, 8'h92);
        chk_rd(ADDR_RX_DATA, 8'h01);
        wr(ADDR_EVT_MASK, 8'h04);
        `CHK(irq, 1'b1)
        wr(ADDR_EVT_STATUS, 8'h04);
        `CHK(irq, 1'b0)
        wr(ADDR_RX_STATUS, 8'h80);
        chk_rd(ADDR_RX_STATUS, 8'h80);
        $display("done: overrun");
    endtask
    task automatic t_slave();
        wr(ADDR_TX_STATUS, 8'h10);
        wr(ADDR_RX_STATUS, 8'h90);
        @(posedge clk_sys);
        sleep <= 1'b1;
        global_interrupt_enable <= 1'b1;
        peer.send_sync(8'h5A);
        wait_ri();
        `CHK(wake, 1'b1)
        `CHK(vector_request, 1'b1)
        `CHK(clock_pin_oe_n, 1'b1)
        @(posedge clk_sys);
        sleep <= 1'b0;
        chk_rd(ADDR_RX_DATA, 8'h5A);
        $display("done: sync slave in sleep");
    endtask
    task automatic t_master();
        wr(ADDR_TX_STATUS, 8'h94);
        wr(ADDR_RX_STATUS, 8'hA0);
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK(clock_pin_oe_n, 1'b0)
        // the master clock must actually toggle on the pin
        for (int i = 0; i < 20 && clock_pin_o !== 1'b1; i++)
            @(posedge clk_sys);
        #1;
        `CHK(clock_pin_o, 1'b1)
        wait_ri();
        `CHK(clock_pin_o, 1'b0)
        chk_rd(ADDR_RX_STATUS, 8'h80);
        chk_rd(ADDR_RX_DATA, 8'hFF);
        // continuous wins over single: single must survive a word
        wr(ADDR_RX_STATUS, 8'hB0);
        wait_ri();
        chk_rd(ADDR_RX_STATUS, 8'hB0);
        chk_rd(ADDR_RX_DATA, 8'hFF);
        wr(ADDR_RX_STATUS, 8'h80);
        $display("done: sync master single");
    endtask
    task automatic stop_test();
        $display("counts: %0d mismatches, %0d comparisons", n_errors,
                 comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // reset for twelve cycles, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_async8();
        t_addr();
        t_frame();
        t_overrun();
        t_slave();
        t_master();
        stop_test();
    end
endmodule
`default_nettype wire
